// [ssp_pkg.sv]
// package: register map, field positions and timing for the slave serial port
package ssp_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] SSP_OFS_INTCTL = 8'h00; // global interrupt control
  localparam logic [7:0] SSP_OFS_FLAGS  = 8'h04; // peripheral flags one
  localparam logic [7:0] SSP_OFS_ENABLE = 8'h08; // peripheral enables one
  localparam logic [7:0] SSP_OFS_RCSTA  = 8'h0c; // receive status/control
  localparam logic [7:0] SSP_OFS_TXHOLD = 8'h10; // transmit holding
  localparam logic [7:0] SSP_OFS_TXSTA  = 8'h14; // transmit status/control
  localparam logic [7:0] SSP_OFS_RXBUF  = 8'h18; // receive buffer
  // global interrupt control fields
  localparam int SSP_B_GIE  = 7;
  localparam int SSP_B_PERIPHERAL_IRQ_ENABLE = 6;
  // flag / enable fields
  localparam int SSP_B_RCIF = 5;
  localparam int SSP_B_TXIF = 4;
  // receive status/control fields
  localparam int SSP_B_PORT_ENABLE  = 7;
  localparam int SSP_B_RX9   = 6;
  localparam int SSP_B_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int SSP_B_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int SSP_B_OERR  = 1;
  localparam int SSP_B_RX9D  = 0;
  // transmit status/control fields
  localparam int SSP_B_CLOCK_SOURCE_SELECT = 7;
  localparam int SSP_B_TX9  = 6;
  localparam int SSP_B_TRANSMIT_ENABLE_BIT = 5;
  localparam int SSP_B_SYNC = 4;
  localparam int SSP_B_SHIFT_REGISTER_EMPTY = 1;
  localparam int SSP_B_TRANSMIT_NINTH_DATA = 0;
  // reset values
  localparam logic [7:0] SSP_RST_CTRL = 8'h00;
  // controller-side shift clock: half period in system clocks
  localparam int SSP_LINK_PERIOD_NS = 160;
  localparam int SSP_CLK_PERIOD_NS  = 10;
  localparam int SSP_HALF_CYC = SSP_LINK_PERIOD_NS / SSP_CLK_PERIOD_NS / 2;
  // controller register offsets
  localparam logic [7:0] SSP_OFS_CCTRL = 8'h00; // ctrl: go, rx, nine
  localparam logic [7:0] SSP_OFS_CTXD  = 8'h04; // tx word (9 bits)
  localparam logic [7:0] SSP_OFS_CRXD  = 8'h08; // rx word (9 bits)
  localparam logic [7:0] SSP_OFS_CSTAT = 8'h0c; // bit0 busy, bit1 rx valid
  localparam int SSP_C_GO   = 0;
  localparam int SSP_C_RX   = 1;
  localparam int SSP_C_NINE = 2;
endpackage

// [ssp_link_if.sv]
// interface: shift clock and data line between master and slave port
`timescale 1ns/1ps
interface ssp_link_if;
  logic sck;       // shift clock, driven by the master
  logic dat_m_o;   // master data out
  logic dat_m_oe;  // master data enable
  logic dat_s_o;   // slave data out
  logic dat_s_oe;  // slave data enable
  logic dat;       // resolved data line (pulled high when idle)
  assign dat = dat_m_oe ? dat_m_o : (dat_s_oe ? dat_s_o : 1'b1);
  modport slave  (input sck, input dat, output dat_s_o, output dat_s_oe);
  modport master (output sck, input dat, output dat_m_o, output dat_m_oe);
endinterface

// [ssp_sync2.sv]
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module ssp_sync2 (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg; // first stage, read only by second stage
  // two stages
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      // both pins idle high: resetting low would fake an edge after reset
      meta_reg <= 1'b1;
      q_out    <= 1'b1;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// [ssp_slave.sv]
// slave end: registered serial port clocked by the external master
`timescale 1ns/1ps
module ssp_slave
  import ssp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        sleep_in,     // chip in sleep or idle
  ssp_link_if.slave        link,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             wake_out,     // wake from low power
  output logic             vector_out    // branch to interrupt vector
);
  logic [7:0] intctl_reg;  // global interrupt control
  logic [7:0] enable_reg;  // peripheral enables
  logic [7:0] rcsta_reg;   // receive control (writable part)
  logic [7:0] txsta_reg;   // transmit control (writable part)
  logic [8:0] hold_reg;    // transmit holding, ninth bit on top
  logic       hold_full_reg;
  logic [8:0] tsr_reg;     // transmit shift register
  logic       tsr_busy_reg;
  logic [8:0] rsr_reg;     // receive shift register
  logic [3:0] bit_cnt_reg; // bits done in current word
  logic [7:0] rxbuf_reg;   // receive buffer
  logic       rx9d_reg;
  logic       rxfull_reg;
  logic       oerr_reg;
  // synchronised pin levels and the previous clock sample; the sync
  // stages reset to the idle-high level so no false edge follows reset
  logic       sck_s;       // shift clock after two flops
  logic       sck_d_reg;   // shift clock one cycle earlier
  logic       dat_s;       // data line after two flops
  // pin inputs pass two flops before any logic
  ssp_sync2 u_sck (.clk_in(clk_in), .srst_in(srst_in),
                   .d_in(link.sck), .q_out(sck_s));
  ssp_sync2 u_dat (.clk_in(clk_in), .srst_in(srst_in),
                   .d_in(link.dat), .q_out(dat_s));
  // decode
  // an access completes in the cycle in which pready stands
  wire acc       = psel_in && penable_in;
  wire wr        = acc && pwrite_in;
  wire rd        = acc && !pwrite_in;
  wire wr_hold   = wr && paddr_in == SSP_OFS_TXHOLD;
  wire rd_buf    = rd && paddr_in == SSP_OFS_RXBUF;
  wire wr_rcsta  = wr && paddr_in == SSP_OFS_RCSTA;
  wire port_enable      = rcsta_reg[SSP_B_PORT_ENABLE];
  // slave mode: sync set, clock source cleared
  wire slave_on  = port_enable && txsta_reg[SSP_B_SYNC]
                   && !txsta_reg[SSP_B_CLOCK_SOURCE_SELECT];
  wire continuous_receive_enable      = rcsta_reg[SSP_B_CONTINUOUS_RECEIVE_ENABLE];
  // single receive is ignored here; continuous decides direction
  wire rx_mode   = slave_on && continuous_receive_enable;
  wire tx_mode   = slave_on && !continuous_receive_enable
                   && txsta_reg[SSP_B_TRANSMIT_ENABLE_BIT];
  wire nine_tx   = txsta_reg[SSP_B_TX9];
  wire nine_rx   = rcsta_reg[SSP_B_RX9];
  wire sck_rise  = sck_s && !sck_d_reg;
  wire sck_fall  = !sck_s && sck_d_reg;
  wire [3:0] last_tx = nine_tx ? 4'h8 : 4'h7;
  wire [3:0] last_rx = nine_rx ? 4'h8 : 4'h7;
  wire tx_done   = tsr_busy_reg && sck_rise && bit_cnt_reg == last_tx;
  wire rx_done   = rx_mode && sck_fall && bit_cnt_reg == last_rx;
  // holding empty is the transmit flag; cleared only by a new write
  wire txif      = !hold_full_reg;
  wire rcif      = rxfull_reg;
  wire [7:0] flags = {2'b00, rcif, txif, 4'h0};
  wire irq = (txif && enable_reg[SSP_B_TXIF] && tx_mode)
           || (rcif && enable_reg[SSP_B_RCIF]);
  wire [8:0] rx_word = {dat_s, rsr_reg[8:1]};
  // register read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (paddr_in)
      SSP_OFS_INTCTL: rd_mux = intctl_reg;
      SSP_OFS_FLAGS:  rd_mux = flags;
      SSP_OFS_ENABLE: rd_mux = enable_reg;
      SSP_OFS_RCSTA:  rd_mux = {rcsta_reg[7:2], oerr_reg, rx9d_reg};
      SSP_OFS_TXSTA:  rd_mux = {txsta_reg[7:2], !tsr_busy_reg,
                                txsta_reg[0]};
      SSP_OFS_RXBUF:  rd_mux = rxbuf_reg;
      default:        rd_mux = 8'h00;
    endcase
  end
  wire bad_addr = paddr_in > SSP_OFS_RXBUF || paddr_in[1:0] != 2'b00;
  // bus answer, one cycle access phase
  // error rides with pready so the master sees both at one edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      wake_out    <= 1'b0;
      vector_out  <= 1'b0;
    end else begin
      pready_out  <= psel_in && !pready_out;
      pslverr_out <= psel_in && !pready_out && bad_addr;
      prdata_out  <= {24'h000000, rd_mux};
      // wake runs regardless of sleep; vector needs both enables
      wake_out    <= irq;
      vector_out  <= irq && intctl_reg[SSP_B_GIE]
                     && intctl_reg[SSP_B_PERIPHERAL_IRQ_ENABLE];
    end
  end
  // writable control registers
  // writes land at the access edge, while pready is high
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      intctl_reg <= SSP_RST_CTRL;
      enable_reg <= SSP_RST_CTRL;
      rcsta_reg  <= SSP_RST_CTRL;
      txsta_reg  <= SSP_RST_CTRL;
    end else if (wr && pready_out) begin
      if (paddr_in == SSP_OFS_INTCTL) intctl_reg <= pwdata_in[7:0];
      if (paddr_in == SSP_OFS_ENABLE) enable_reg <= pwdata_in[7:0];
      if (wr_rcsta) rcsta_reg <= pwdata_in[7:0];
      if (paddr_in == SSP_OFS_TXSTA)  txsta_reg <= pwdata_in[7:0];
    end
  end
  // transmit path: holding -> shifter, data changes on rising edge
  // disabling the port drops both words, so the flag then reads set
  always_ff @(posedge clk_in) begin
    sck_d_reg <= sck_s;
    if (srst_in || !port_enable) begin
      hold_reg      <= 9'h000;
      hold_full_reg <= 1'b0;
      tsr_reg       <= 9'h1ff;
      tsr_busy_reg  <= 1'b0;
    end else begin
      if (wr_hold && pready_out) begin
        hold_reg      <= {txsta_reg[SSP_B_TRANSMIT_NINTH_DATA], pwdata_in[7:0]};
        hold_full_reg <= 1'b1;
      end else if (hold_full_reg && tx_mode
                   && (!tsr_busy_reg || tx_done)) begin
        // first word goes at once; next one after the shift ends
        tsr_reg       <= hold_reg;
        tsr_busy_reg  <= 1'b1;
        hold_full_reg <= 1'b0;
      end else if (tx_done) begin
        tsr_busy_reg  <= 1'b0;
      end
      if (tsr_busy_reg && sck_rise && !tx_done)
        tsr_reg <= {1'b1, tsr_reg[8:1]};
    end
  end
  // bit counter shared by both directions (half duplex)
  // cleared whenever idle so a cut frame leaves no stale count
  always_ff @(posedge clk_in) begin
    if (srst_in || !slave_on || (!tsr_busy_reg && !rx_mode))
      bit_cnt_reg <= 4'h0;
    else if (tx_done || rx_done)
      bit_cnt_reg <= 4'h0;
    else if ((tsr_busy_reg && sck_rise) || (rx_mode && sck_fall))
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end
  // receive path: shift on falling edge, transfer whole word to buffer
  // an overrun drops the new word and keeps the unread one
  always_ff @(posedge clk_in) begin
    if (srst_in || !port_enable) begin
      rsr_reg    <= 9'h000;
      rxbuf_reg  <= 8'h00;
      rx9d_reg   <= 1'b0;
      rxfull_reg <= 1'b0;
      oerr_reg   <= 1'b0;
    end else begin
      if (rx_mode && sck_fall) rsr_reg <= rx_word;
      if (rx_done) begin
        if (rxfull_reg) oerr_reg <= 1'b1;  // old word unread: overrun
        else begin
          // nine bits fill the shifter, eight leave bit 0 stale
          rxbuf_reg  <= nine_rx ? rx_word[7:0] : rx_word[8:1];
          rx9d_reg   <= nine_rx ? rx_word[8] : 1'b0;
          rxfull_reg <= 1'b1;
        end
      end else if (rd_buf && pready_out) rxfull_reg <= 1'b0;
      if (!continuous_receive_enable) oerr_reg <= 1'b0;
    end
  end
  // data pin driven only while a word shifts out
  // receive mode never drives, so a mode change cannot clash
  assign link.dat_s_oe = tsr_busy_reg && tx_mode;
  assign link.dat_s_o  = tsr_reg[0];
endmodule

// [ssp_master.sv]
// master end: drives the shift clock, sends or receives one word
`timescale 1ns/1ps
module ssp_master
  import ssp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  ssp_link_if.master       link,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00, SSP_LOW = 2'b01, SSP_HIGH = 2'b10
  } ssp_state_e;
  ssp_state_e st_reg;
  logic [2:0] ctrl_reg;   // nine, rx, go
  logic [8:0] sh_reg;     // shift data
  logic [8:0] rxd_reg;    // last received word
  logic       rxv_reg;    // received word valid
  logic [3:0] bits_reg;   // bits done
  logic [7:0] div_reg;    // half period counter
  logic       sck_reg, dat_reg;
  logic       dat_s;
  // data line from slave crosses in through two flops
  ssp_sync2 u_dat (.clk_in(clk_in), .srst_in(srst_in),
                   .d_in(link.dat), .q_out(dat_s));
  wire acc      = psel_in && penable_in && pready_out;
  wire wr       = acc && pwrite_in;
  wire half     = div_reg == 8'(SSP_HALF_CYC - 1);
  wire [3:0] last = ctrl_reg[SSP_C_NINE] ? 4'h8 : 4'h7;
  wire busy     = st_reg != SSP_IDLE;
  // bus answer one cycle after setup
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in && !pready_out;
      pslverr_out <= 1'b0;
      case (paddr_in)
        SSP_OFS_CCTRL: prdata_out <= {29'h0, ctrl_reg};
        SSP_OFS_CRXD:  prdata_out <= {23'h0, rxd_reg};
        SSP_OFS_CSTAT: prdata_out <= {30'h0, rxv_reg, busy};
        default:       prdata_out <= 32'h0000_0000;
      endcase
    end
  end
  // sequencer: clock low half drives data, falling edge sampled by slave
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg   <= SSP_IDLE;
      ctrl_reg <= 3'h0;
      sh_reg   <= 9'h000;
      rxd_reg  <= 9'h000;
      rxv_reg  <= 1'b0;
      bits_reg <= 4'h0;
      div_reg  <= 8'h00;
      sck_reg  <= 1'b1;
      dat_reg  <= 1'b1;
    end else begin
      if (wr && paddr_in == SSP_OFS_CTXD) sh_reg <= pwdata_in[8:0];
      if (acc && !pwrite_in && paddr_in == SSP_OFS_CRXD) rxv_reg <= 1'b0;
      div_reg <= half ? 8'h00 : div_reg + 8'h01;
      case (st_reg)
        SSP_IDLE: begin
          sck_reg <= 1'b1;
          if (wr && paddr_in == SSP_OFS_CCTRL && pwdata_in[SSP_C_GO]) begin
            ctrl_reg <= pwdata_in[2:0];
            bits_reg <= 4'h0;
            div_reg  <= 8'h00;
            st_reg   <= SSP_LOW;
            sck_reg  <= 1'b0;
            dat_reg  <= pwdata_in[SSP_C_RX] ? 1'b1 : sh_reg[0];
          end
        end
        SSP_LOW: if (half) begin
          // the slave moves its bit just after each rise, so the bit
          // seen at the end of the low half is the settled one
          if (ctrl_reg[SSP_C_RX])
            sh_reg <= {dat_s, sh_reg[8:1]};
          sck_reg <= 1'b1;
          st_reg  <= SSP_HIGH;
        end
        SSP_HIGH: if (half) begin
          if (!ctrl_reg[SSP_C_RX])
            sh_reg <= {1'b1, sh_reg[8:1]};
          if (bits_reg == last) begin
            st_reg  <= SSP_IDLE;
            if (ctrl_reg[SSP_C_RX]) begin
              rxd_reg <= ctrl_reg[SSP_C_NINE] ? sh_reg
                                              : {1'b0, sh_reg[8:1]};
              rxv_reg <= 1'b1;
            end
          end else begin
            bits_reg <= bits_reg + 4'h1;
            sck_reg  <= 1'b0;
            st_reg   <= SSP_LOW;
            dat_reg  <= ctrl_reg[SSP_C_RX] ? 1'b1 : sh_reg[1];
          end
        end
        default: st_reg <= SSP_IDLE;
      endcase
    end
  end
  assign link.sck      = sck_reg;
  assign link.dat_m_o  = dat_reg;
  assign link.dat_m_oe = busy && !ctrl_reg[SSP_C_RX];
endmodule

// [ssp_link_monitor.sv]
// checker: shift clock timing and data framing on the link
`timescale 1ns/1ps
module ssp_link_monitor (
  input wire logic clk_in,      // system clock
  input wire logic srst_in,     // synchronous reset
  input wire logic sck_in,      // shift clock from the master
  input wire logic dat_m_in,    // master data
  input wire logic dat_m_oe_in, // master drive enable
  input wire logic dat_s_in,    // slave data
  input wire logic dat_s_oe_in, // slave drive enable
  input wire logic dat_in       // resolved line, idle high
);
  // one clock domain, so one clocking and one disable for all
  default clocking mon_cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  // half duplex: a clash would corrupt the word silently
  a_link_no_clash: assert property (
    !(dat_m_oe_in && dat_s_oe_in))
    else $error("both ends drive the data line");
  // master makes the clock: exactly eight cycles low
  a_sck_low_half: assert property (
    $fell(sck_in) |-> !sck_in [*8] ##1 sck_in)
    else $error("shift clock low half wrong length");
  // high half at least eight cycles, longer when idle
  a_sck_high_half: assert property (
    $rose(sck_in) |-> sck_in [*8])
    else $error("shift clock high half too short");
  // slave bits move only in the high half, so they are steady at a fall
  a_slave_bit_rise: assert property (
    dat_s_oe_in && $past(dat_s_oe_in) && $changed(dat_s_in) |-> sck_in)
    else $error("slave data changed while clock low");
  // master bits move only in the low half
  a_master_bit_fall: assert property (
    dat_m_oe_in && $past(dat_m_oe_in) && $changed(dat_m_in) |-> !sck_in)
    else $error("master data changed while clock high");
  // slave takes the line while the clock idles high
  a_slave_start_idle: assert property (
    $rose(dat_s_oe_in) |-> sck_in)
    else $error("slave started driving in low half");
  // slave lets go after the final rise, never mid low half
  a_slave_end_rise: assert property (
    $fell(dat_s_oe_in) |-> sck_in)
    else $error("slave released line in low half");
  // master drive begins from a falling edge
  a_master_start_low: assert property (
    $rose(dat_m_oe_in) |-> !sck_in)
    else $error("master started driving in high half");
  // main scenarios seen
  c_slave_frame: cover property ($rose(dat_s_oe_in));
  c_master_frame: cover property ($rose(dat_m_oe_in));
  c_line_low: cover property (!dat_in && $fell(sck_in));
endmodule

// [sync_slave_serial_port_test.sv]
// testbench: both ends joined over the link, driven over their apb ports
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  err_count++; $display("unexpected %s exp %h got %h", nm, exp, got); end end
module sync_slave_serial_port_test import ssp_pkg::*;;
  logic        clk_in;              // system clock
  logic        srst_in = 1'b1;      // synchronous reset
  logic        sleep_in = 1'b0;     // low power level
  logic        psel_s = 1'b0;       // slave select
  logic        psel_m = 1'b0;       // master select
  logic        penable = 1'b0;      // shared access strobe
  logic        pwrite = 1'b0;       // shared direction
  logic [7:0]  paddr = 8'h00;       // shared address
  logic [31:0] pwdata = 32'h0;      // shared write data
  logic [31:0] prdata_s, prdata_m;  // read data per end
  logic        pready_s, pready_m;  // ready per end
  logic        perr_s, perr_m;      // error per end
  logic        wake, vect;          // slave wake and vector
  logic [31:0] rdv;                 // last read data
  logic        errv;                // last error response
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;             // watchdog count
  ssp_link_if  link_if ();
  ssp_slave i_ssp_slave (.clk_in(clk_in), .srst_in(srst_in),
    .sleep_in(sleep_in), .link(link_if.slave), .psel_in(psel_s),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata_s), .pready_out(pready_s),
    .pslverr_out(perr_s), .wake_out(wake), .vector_out(vect));
  ssp_master i_ssp_master (.clk_in(clk_in), .srst_in(srst_in),
    .link(link_if.master), .psel_in(psel_m), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_m), .pready_out(pready_m), .pslverr_out(perr_m));
  ssp_link_monitor i_ssp_link_monitor (.clk_in(clk_in), .srst_in(srst_in),
    .sck_in(link_if.sck), .dat_m_in(link_if.dat_m_o),
    .dat_m_oe_in(link_if.dat_m_oe), .dat_s_in(link_if.dat_s_o),
    .dat_s_oe_in(link_if.dat_s_oe), .dat_in(link_if.dat));
  // 100 mhz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // verdict and stop, shared by main flow and watchdog
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard: the tests need about a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic sl, input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge clk_in);
    psel_s  <= sl;
    psel_m  <= !sl;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while ((sl ? pready_s : pready_m) !== 1'b1);
    rdv  = sl ? prdata_s : prdata_m;
    errv = sl ? perr_s : perr_m;
    psel_s  <= 1'b0;
    psel_m  <= 1'b0;
    penable <= 1'b0;
  endtask
  // slave register write and read
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b1, a, {24'h0, d});
  endtask
  task automatic sr(input logic [7:0] a);
    xfer(1'b1, 1'b0, a, 32'h0);
  endtask
  // master: load tx word, start, poll busy until the word is done
  task automatic mrun(input logic [8:0] w, input logic [7:0] ctl);
    xfer(1'b0, 1'b1, SSP_OFS_CTXD, {23'h0, w});
    xfer(1'b0, 1'b1, SSP_OFS_CCTRL, {24'h0, ctl});
    do begin
      xfer(1'b0, 1'b0, SSP_OFS_CSTAT, 32'h0);
    end while (rdv[0] !== 1'b0);
  endtask
  task automatic mr;
    xfer(1'b0, 1'b0, SSP_OFS_CRXD, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    // reset state and a refused address
    sr(SSP_OFS_TXSTA);
    `CHK("tx status", 8'h02, rdv[7:0])
    sr(SSP_OFS_FLAGS);
    `CHK("flags", 8'h10, rdv[7:0])
    xfer(1'b1, 1'b0, 8'h1c, 32'h0);
    `CHK("unmapped err", 1'b1, errv)
    $display("test reset done");
    // two words queued while asleep; the flag waits for the second
    sleep_in <= 1'b1;
    sw(SSP_OFS_INTCTL, 8'hc0);
    sw(SSP_OFS_ENABLE, 8'h10);
    sw(SSP_OFS_RCSTA, 8'h80);
    sw(SSP_OFS_TXSTA, 8'h30);
    sw(SSP_OFS_TXHOLD, 8'ha5);
    sw(SSP_OFS_TXHOLD, 8'h3c);
    sr(SSP_OFS_FLAGS);
    `CHK("flags held", 8'h00, rdv[7:0])
    sr(SSP_OFS_TXSTA);
    `CHK("tx status", 8'h30, rdv[7:0])
    `CHK("wake held", 1'b0, wake)
    mrun(9'h0, 8'h03);
    `CHK("rx valid", 1'b1, rdv[1])
    mr();
    `CHK("first word", 9'h0a5, rdv[8:0])
    sr(SSP_OFS_FLAGS);
    `CHK("flags", 8'h10, rdv[7:0])
    `CHK("wake", 1'b1, wake)
    `CHK("vector", 1'b1, vect)
    mrun(9'h0, 8'h03);
    mr();
    `CHK("second word", 9'h03c, rdv[8:0])
    sr(SSP_OFS_TXSTA);
    `CHK("tx status", 8'h32, rdv[7:0])
    $display("test slave transmit done");
    // nine-bit transmit, ninth bit last
    sw(SSP_OFS_TXSTA, 8'h71);
    sw(SSP_OFS_TXHOLD, 8'h5a);
    mrun(9'h0, 8'h07);
    mr();
    `CHK("nine-bit word", 9'h15a, rdv[8:0])
    $display("test nine-bit transmit done");
    // nine-bit receive while asleep
    sw(SSP_OFS_TXSTA, 8'h10);
    sw(SSP_OFS_ENABLE, 8'h20);
    sw(SSP_OFS_RCSTA, 8'hd0);
    mrun(9'h1c3, 8'h05);
    `CHK("rx wake", 1'b1, wake)
    `CHK("rx vector", 1'b1, vect)
    sr(SSP_OFS_RCSTA);
    `CHK("rx status", 8'hd1, rdv[7:0])
    sr(SSP_OFS_RXBUF);
    `CHK("rx buffer", 8'hc3, rdv[7:0])
    sr(SSP_OFS_FLAGS);
    `CHK("flags", 8'h10, rdv[7:0])
    $display("test slave receive done");
    // overrun with single receive also set, then recovery
    sw(SSP_OFS_RCSTA, 8'hb0);
    mrun(9'h011, 8'h01);
    mrun(9'h022, 8'h01);
    sr(SSP_OFS_RCSTA);
    `CHK("overrun", 7'h59, rdv[7:1])
    sr(SSP_OFS_RXBUF);
    `CHK("kept word", 8'h11, rdv[7:0])
    sw(SSP_OFS_RCSTA, 8'ha0);
    sr(SSP_OFS_RCSTA);
    `CHK("overrun cleared", 7'h50, rdv[7:1])
    $display("test overrun done");
    end_sim();
  end
endmodule
